// File: rtl/hsp_pkg.sv
`default_nettype none

package hsp_pkg;

    // command opcodes carried in the first byte of a frame
    localparam logic [7:0] OP_READ  = 8'h01;
    localparam logic [7:0] OP_WRITE = 8'h02;
    localparam logic [7:0] OP_DMA   = 8'h03;

    // frame layout: opcode, address, length, turnaround, then data words
    localparam int HDR_BITS  = 32;
    localparam int TURN_BITS = 8;
    localparam int WORD_BITS = 32;

    // cycles after reset release before strap and mode pins are taken
    localparam logic [1:0] STRAP_WAIT = 2'h3;

    // reset values
    localparam logic [31:0] WORD_RST = 32'h0;

    // command header as it arrives, most significant bit first
    typedef struct packed {
        logic [7:0]  op;
        logic [15:0] addr;
        logic [7:0]  len;
    } hsp_hdr_s;

    // one register access toward the device core
    typedef struct packed {
        logic [15:0] addr;
        logic [31:0] data;
    } hsp_acc_s;

    typedef enum logic [1:0] {
        RD_IDLE = 2'h1,
        RD_WAIT = 2'h2
    } hsp_rd_e;

endpackage

`default_nettype wire

// File: rtl/hsp_slave_port.sv
// What this block does
// (R01) port works right after reset, no setup, when the strap pin is high
// (R02) only the strap pin chooses serial port versus sd-style port
// (R03) strap pin low: sd-style port owns the shared pins instead
// (R04) select_n is active low; while high all bus traffic is ignored
// (R05) serial output is released (enable low) while deselected
// (R06) full duplex: one bit in and one bit out per serial clock
// (R07) host data sampled on mosi, answer driven on miso
// (R08) all four polarity/phase modes, 0:0/0, 1:0/1, 2:1/0, 3:1/1
// (R09) frames let the host read, write any register and start dma
// (R10) frame is opcode, address, length, turnaround, then data words
// (R11) mode taken at reset; deselect aborts the frame and clears counters
`timescale 1ns/1ns
`default_nettype none

module hsp_slave_port (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        host_if_strap,
    input  wire logic        mode_cpol,
    input  wire logic        mode_cpha,
    input  wire logic        sck,
    input  wire logic        select_n,
    input  wire logic        mosi,
    output logic             miso,
    output logic             miso_oe,
    output logic             spi_port_en,
    output logic             sd_port_en,
    output logic             reg_rd,
    output logic             reg_wr,
    output hsp_pkg::hsp_acc_s reg_acc,
    input  wire logic        reg_rd_ack,
    input  wire logic [31:0] reg_rd_data,
    output logic             dma_start,
    output hsp_pkg::hsp_hdr_s dma_req
);

    // ---------------- system clock: strap and mode capture ----------------
    logic       strap_s1, strap_s2, cpol_s1, cpol_s2, cpha_s1, cpha_s2;
    logic [1:0] wait_cnt;
    logic       taken;
    logic       cpol, cpha;

    // pins pass two flops before anything looks at them
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            {strap_s1, strap_s2} <= 2'h0;
            {cpol_s1, cpol_s2}   <= 2'h0;
            {cpha_s1, cpha_s2}   <= 2'h0;
        end else begin
            strap_s1 <= host_if_strap;
            strap_s2 <= strap_s1;
            cpol_s1  <= mode_cpol;
            cpol_s2  <= cpol_s1;
            cpha_s1  <= mode_cpha;
            cpha_s2  <= cpha_s1;
        end
    end

    // straps are caught once after release and then frozen; no pin mux involved
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wait_cnt    <= 2'h0;
            taken       <= 1'b0;
            spi_port_en <= 1'b0;
            sd_port_en  <= 1'b0;
            cpol        <= 1'b0;
            cpha        <= 1'b0;
        end else if (!taken) begin
            wait_cnt <= wait_cnt + 2'h1;
            if (wait_cnt == hsp_pkg::STRAP_WAIT) begin
                taken       <= 1'b1;
                spi_port_en <= strap_s2;   // R01 R02
                sd_port_en  <= !strap_s2;  // R03
                cpol        <= cpol_s2;    // R11
                cpha        <= cpha_s2;    // R11
            end
        end
    end

    // ---------------- link clock domain ----------------
    // mode bits are frozen long before any frame, so they feed the clock
    // steering directly; sampling edge becomes the rising edge of sck_s
    wire sck_s    = sck ^ (cpol ^ cpha);                      // R08
    wire link_rst = rst | select_n | !spi_port_en;            // R04 R11
    assign miso_oe = !select_n & spi_port_en;                 // R05

    logic [5:0]        hcnt;
    logic              hdr_done;
    logic [4:0]        dcnt;
    logic [31:0]       sh;
    hsp_pkg::hsp_hdr_s hdr;
    logic [31:0]       txsh;

    wire [31:0]        next_sh  = {sh[30:0], mosi};           // R07
    wire hsp_pkg::hsp_hdr_s next_hdr = next_sh;
    wire hdr_end  = !hdr_done && hcnt == 6'(hsp_pkg::HDR_BITS - 1);
    wire turn_end = !hdr_done && hcnt == 6'(hsp_pkg::HDR_BITS + hsp_pkg::TURN_BITS - 1);
    wire in_data  = hdr_done && hdr.len != 8'h0;
    wire word_end = in_data && dcnt == 5'h1f;
    wire is_rd    = hdr.op == hsp_pkg::OP_READ;
    wire is_wr    = hdr.op == hsp_pkg::OP_WRITE;

    // frame parser; an early deselect drops everything gathered so far
    always_ff @(posedge sck_s or posedge link_rst) begin
        if (link_rst) begin
            hcnt     <= 6'h0;
            hdr_done <= 1'b0;
            dcnt     <= 5'h0;
            sh       <= hsp_pkg::WORD_RST;
            hdr      <= '0;
        end else begin
            sh <= next_sh;                                    // R06
            if (!hdr_done) begin
                hcnt <= hcnt + 6'h1;
                if (hdr_end)
                    hdr <= next_hdr;                          // R10
                if (turn_end)
                    hdr_done <= 1'b1;
            end else if (in_data) begin
                dcnt <= dcnt + 5'h1;
                if (word_end) begin
                    hdr.len  <= hdr.len - 8'h1;
                    hdr.addr <= hdr.addr + 16'h1;
                end
            end
        end
    end

    // events toward the system clock: toggles plus held payloads; these
    // survive deselect so no false toggle edge is produced by an abort
    logic        rd_tgl, wr_tgl, dma_tgl;
    logic [15:0] rd_addr;
    hsp_pkg::hsp_acc_s wr_hold;
    hsp_pkg::hsp_hdr_s dma_hold;

    wire first_rd = hdr_end && next_hdr.op == hsp_pkg::OP_READ && next_hdr.len != 8'h0;
    wire next_rd  = in_data && is_rd && dcnt == 5'h0 && hdr.len > 8'h1;
    wire wr_word  = word_end && is_wr;
    wire dma_go   = hdr_end && next_hdr.op == hsp_pkg::OP_DMA;

    always_ff @(posedge sck_s or posedge rst) begin
        if (rst) begin
            rd_tgl   <= 1'b0;
            wr_tgl   <= 1'b0;
            dma_tgl  <= 1'b0;
            rd_addr  <= 16'h0;
            wr_hold  <= '0;
            dma_hold <= '0;
        end else begin
            if (first_rd || next_rd) begin                    // R09
                rd_tgl  <= !rd_tgl;
                rd_addr <= first_rd ? next_hdr.addr : hdr.addr + 16'h1;
            end
            if (wr_word) begin                                // R09
                wr_tgl  <= !wr_tgl;
                wr_hold <= {hdr.addr, next_sh};
            end
            if (dma_go) begin                                 // R09
                dma_tgl  <= !dma_tgl;
                dma_hold <= next_hdr;
            end
        end
    end

    // answer side: the word is loaded at its first bit and shifted out after;
    // the command phase and writes return zeros
    logic [31:0] rd_word;
    wire load_tx = in_data && is_rd && dcnt == 5'h0;

    always_ff @(negedge sck_s or posedge link_rst) begin
        if (link_rst) begin
            miso <= 1'b0;
            txsh <= hsp_pkg::WORD_RST;
        end else if (load_tx) begin
            miso <= rd_word[31];                              // R06 R10
            txsh <= {rd_word[30:0], 1'b0};
        end else begin
            miso <= txsh[31];
            txsh <= {txsh[30:0], 1'b0};
        end
    end

    // ---------------- system clock: requests to the core ----------------
    logic [2:0] rd_sync, wr_sync, dma_sync;

    // stage 0 feeds only stage 1; the edge test looks at stages 1 and 2
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_sync  <= 3'h0;
            wr_sync  <= 3'h0;
            dma_sync <= 3'h0;
        end else begin
            rd_sync  <= {rd_sync[1:0], rd_tgl};
            wr_sync  <= {wr_sync[1:0], wr_tgl};
            dma_sync <= {dma_sync[1:0], dma_tgl};
        end
    end

    wire rd_ev  = rd_sync[2] ^ rd_sync[1];
    wire wr_ev  = wr_sync[2] ^ wr_sync[1];
    wire dma_ev = dma_sync[2] ^ dma_sync[1];

    hsp_pkg::hsp_rd_e rd_st, next_rd_st;

    always_comb begin
        case (rd_st)
            hsp_pkg::RD_IDLE: next_rd_st = rd_ev ? hsp_pkg::RD_WAIT : hsp_pkg::RD_IDLE;
            hsp_pkg::RD_WAIT: next_rd_st = reg_rd_ack ? hsp_pkg::RD_IDLE : hsp_pkg::RD_WAIT;
            default:          next_rd_st = hsp_pkg::RD_IDLE;
        endcase
    end

    // payloads are set with their toggle and stay stable for many link bits after it is seen
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_st     <= hsp_pkg::RD_IDLE;
            reg_rd    <= 1'b0;
            reg_wr    <= 1'b0;
            reg_acc   <= '0;
            rd_word   <= hsp_pkg::WORD_RST;
            dma_start <= 1'b0;
            dma_req   <= '0;
        end else begin
            rd_st     <= next_rd_st;
            reg_rd    <= rd_ev;
            reg_wr    <= wr_ev;
            dma_start <= dma_ev;
            if (rd_ev)
                reg_acc <= {rd_addr, 32'h0};
            else if (wr_ev)
                reg_acc <= wr_hold;
            if (rd_st == hsp_pkg::RD_WAIT && reg_rd_ack)
                rd_word <= reg_rd_data;   // read once by the link at word start
            if (dma_ev)
                dma_req <= dma_hold;
        end
    end

endmodule

`default_nettype wire

// File: verif/hsp_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module hsp_asserts (
    input wire logic              clk,
    input wire logic              rst,
    input wire logic              select_n,
    input wire logic              miso_oe,
    input wire logic              spi_port_en,
    input wire logic              sd_port_en,
    input wire logic              reg_rd,
    input wire logic              reg_wr,
    input wire hsp_pkg::hsp_acc_s reg_acc,
    input wire logic              dma_start
);
    // everything watched here is sampled on the system clock; select_n and miso_oe come from the link side
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    oe_desel_a: assert property (select_n |-> !miso_oe)
        else $error("miso driven while deselected");
    oe_sel_a: assert property (!select_n && spi_port_en |-> miso_oe)
        else $error("miso released while selected");
    oe_sd_a: assert property (sd_port_en |-> !miso_oe)
        else $error("miso driven in sd mode");
    port_excl_a: assert property (!(spi_port_en && sd_port_en))
        else $error("both host ports on");
    port_keep_a: assert property (spi_port_en |=> spi_port_en)
        else $error("serial port dropped");
    rd_pulse_a: assert property (reg_rd |=> !reg_rd)
        else $error("read request too long");
    wr_pulse_a: assert property (reg_wr |=> !reg_wr && !reg_rd)
        else $error("write request too long");
    rd_zero_a: assert property (reg_rd |-> !reg_wr && reg_acc.data == 32'h0)
        else $error("read carries data");
    sd_quiet_a: assert property (sd_port_en |-> !(reg_rd || reg_wr || dma_start))
        else $error("request in sd mode");
    cover property (reg_rd);
    cover property (reg_wr);
    cover property (dma_start);
endmodule
`default_nettype wire

// File: verif/hsp_host.sv
`timescale 1ns/1ns
`default_nettype none
module hsp_host (
    input  wire logic cpol,
    input  wire logic cpha,
    input  wire logic miso_line,
    output logic      sck,
    output logic      select_n,
    output logic      mosi
);
    initial begin
        sck = 1'b0;
        select_n = 1'b1;
        mosi = 1'b0;
    end
    // select edge; the data line is scrambled so stale bits never look valid
    task automatic sel(input logic lo);
        sck = cpol;
        #40 select_n = !lo;
        mosi = !mosi;
        #40;
    endtask
    // n bits msb first; sck idles at cpol and runs only while this task shifts, select is not touched
    task automatic shift(input int n, input logic [31:0] tx, output logic [31:0] rx);
        rx = 32'h0;
        for (int i = n - 1; i >= 0; i--) begin
            if (!cpha) mosi = tx[i];
            #40 sck = !cpol;
            if (cpha) mosi = tx[i];
            else rx[i] = miso_line;
            #40 sck = cpol;
            if (cpha) rx[i] = miso_line;
        end
    endtask
endmodule
`default_nettype wire

// File: verif/tb_host_spi_slave_port.sv
`timescale 1ns/1ns
`default_nettype none
module tb_host_spi_slave_port;
    logic clk = 1'b0, rst = 1'b1, host_if_strap = 1'b1, mode_cpol = 1'b0, mode_cpha = 1'b0;
    logic reg_rd_ack = 1'b0, miso, miso_oe, spi_port_en, sd_port_en, reg_rd, reg_wr, dma_start;
    logic [31:0] reg_rd_data = 32'h0, rx;
    logic [15:0] rd_addr = 16'h0, a;
    logic [2:0] rd_cnt = 3'h0;
    wire sck, select_n, mosi;
    hsp_pkg::hsp_acc_s reg_acc, wq[$];
    hsp_pkg::hsp_hdr_s dma_req, hq[$];
    int fails = 0, num_checks = 0, w, nrd = 0;
    // undriven line shows the inverse so a stale bit is never read as good
    wire miso_line = miso_oe ? miso : !miso;
    hsp_slave_port dut (.clk, .rst, .host_if_strap, .mode_cpol, .mode_cpha, .sck, .select_n,
        .mosi, .miso, .miso_oe, .spi_port_en, .sd_port_en, .reg_rd, .reg_wr, .reg_acc,
        .reg_rd_ack, .reg_rd_data, .dma_start, .dma_req);
    hsp_host host (.cpol(mode_cpol), .cpha(mode_cpha), .miso_line, .sck, .select_n, .mosi);
    always #10 clk = ~clk;
    function automatic logic [31:0] rd_val(input logic [15:0] x);
        return {x ^ 16'h5a5a, x};
    endfunction
    // core side: reads answered after a random delay, requests logged
    // one assignment per signal per edge; data is noise except with the ack
    wire ack_now = !reg_rd && rd_cnt == 3'h1;
    always @(posedge clk) begin
        reg_rd_ack <= ack_now;
        reg_rd_data <= ack_now ? rd_val(rd_addr) : 32'($urandom);
        if (reg_rd) begin
            rd_addr <= reg_acc.addr;
            rd_cnt <= 3'($urandom % 5 + 1);
            nrd <= nrd + 1;
        end else if (rd_cnt != 3'h0) begin
            rd_cnt <= rd_cnt - 3'h1;
        end
        if (reg_wr) wq.push_back(reg_acc);
        if (dma_start) hq.push_back(dma_req);
    end
    task automatic chk(input string what, input logic [47:0] exp, input logic [47:0] got);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // reset with straps set; the odd offset keeps sck apart from clk edges
    task automatic boot(input logic s, input logic [1:0] m);
        @(posedge clk);
        rst <= 1'b1;
        host_if_strap <= s;
        {mode_cpol, mode_cpha} <= m;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        repeat (12) @(posedge clk);
        #7;
    endtask
    // whole frame; cut shifts only 16 bits per data word to test the abort path
    task automatic frame(input logic [7:0] op, input logic [15:0] ad, input int len,
                         input bit cut);
        logic [31:0] r;
        host.sel(1'b1);
        host.shift(32, {op, ad, 8'(len)}, r);
        host.shift(8, 32'h0, r);
        for (int k = 0; k < (op == hsp_pkg::OP_DMA ? 0 : len); k++) begin
            host.shift(cut ? 16 : 32, ~rd_val(ad + 16'(k)), r);
            if (op == hsp_pkg::OP_READ) chk("read word", 48'(rd_val(ad + 16'(k))), 48'(r));
        end
        host.sel(1'b0);
    endtask
    task automatic await(input int n);
        for (w = 0; w < 60 && wq.size() + hq.size() < n; w++) @(posedge clk);
        if (w == 60) begin
            fails++;
            tally_and_finish();
        end
    endtask
    initial begin
        a = 16'($urandom(82));
        for (int m = 0; m < 4; m++) begin
            boot(1'b1, 2'(m));
            wq.delete();
            hq.delete();
            nrd = 0;
            chk("serial port on", 48'h1, 48'(spi_port_en));
            a = 16'($urandom);
            frame(hsp_pkg::OP_READ, a, 2, 1'b0);
            frame(hsp_pkg::OP_READ, a, 0, 1'b0);
            frame(hsp_pkg::OP_WRITE, a + 16'h3, 2, 1'b0);
            frame(hsp_pkg::OP_WRITE, a, 1, 1'b1);
            // traffic for another slave: clocked header while select stays high
            host.shift(32, {hsp_pkg::OP_DMA, a, 8'h1}, rx);
            frame(hsp_pkg::OP_DMA, a, 5, 1'b0);
            await(3);
            chk("read count", 48'h2, 48'(nrd));
            chk("dma count", 48'h1, 48'(hq.size()));
            chk("write count", 48'h2, 48'(wq.size()));
            for (int k = 0; k < 2; k++)
                chk("write", {a + 16'(k + 3), ~rd_val(a + 16'(k + 3))}, wq[k]);
            chk("dma header", 48'({hsp_pkg::OP_DMA, a, 8'h5}), 48'(hq[0]));
            chk("idle oe", 48'h0, 48'(miso_oe));
        end
        boot(1'b0, 2'h0);
        wq.delete();
        hq.delete();
        chk("ports", 48'h1, {46'h0, spi_port_en, sd_port_en});
        frame(hsp_pkg::OP_DMA, a, 1, 1'b0);
        repeat (20) @(posedge clk);
        chk("sd ignores", 48'h0, 48'(hq.size()));
        tally_and_finish();
    end
endmodule
bind hsp_slave_port hsp_asserts chk_u (.clk(clk), .rst(rst), .select_n(select_n),
    .miso_oe(miso_oe), .spi_port_en(spi_port_en), .sd_port_en(sd_port_en), .reg_rd(reg_rd),
    .reg_wr(reg_wr), .reg_acc(reg_acc), .dma_start(dma_start));
`default_nettype wire
